// File: inc/pas_defines.svh
`ifndef PAS_DEFINES_SVH
`define PAS_DEFINES_SVH

`define PAS_ADDR_W         8
`define PAS_DATA_W         16
`define PAS_OFF_ABILITY    8'hc8
`define PAS_OFF_EXPANSION  8'hcc
`define PAS_OFF_MODE_CTRL  8'hd0
`define PAS_OFF_STATUS     8'hd4
`define PAS_BIT_T4         9
`define PAS_BIT_TXF        8
`define PAS_BIT_TXH        7
`define PAS_BIT_10F        6
`define PAS_BIT_10H        5
`define PAS_BIT_PDF        4
`define PAS_BIT_PARTNER_NEXT_PAGE_CAPABLE       3
`define PAS_BIT_NP         2
`define PAS_BIT_PR         1
`define PAS_BIT_PARTNER_NEGOTIATION_CAPABLE       0
`define PAS_BIT_LD         11
`define PAS_BIT_SPEED      9
`define PAS_BIT_DUPLEX     8
`define PAS_BIT_PAUSE      7
`define PAS_RST_LD         1'b0
`define PAS_RXERR_LIMIT    7'h40

`endif

// File: inc/pas_pkg.sv
package pas_pkg;
  // Live inputs from the negotiation engine and receive path
  typedef struct packed {
    logic       t4;
    logic       fast_full;
    logic       fast_half;
    logic       ten_full;
    logic       ten_half;
    logic [4:0] selector;
    logic       next_page;
    logic       negotiation;
  } pas_partner_t;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic pause_on;
  } pas_resolved_t;

  // One-cycle event pulses, same clock domain
  typedef struct packed {
    logic neg_done;
    logic remote_fault;
    logic link_fail;
    logic code_word_ack;
    logic par_fault;
    logic page_rx;
    logic rx_err_pkt;
  } pas_event_t;
endpackage : pas_pkg

// File: hw/pas_regs.sv
// Summary of operation
// - Ability bit 9: partner T4 capability
// - Ability bits 8,7: partner TX full/half
// - Ability bits 6,5: partner 10T full/half
// - Ability bits 4..0: partner selector field
// - Latched bits hold until register read
// - Expansion bit 4 latched parallel fault
// - Expansion bit 3: partner next page
// - Expansion bit 2 always reads zero
// - Expansion bit 1: new page pending
// - Expansion bit 0: partner negotiation capable
// - Mode bit 11 long-cable squelch, rw
// - Status bit 9 resolved speed
// - Status bit 8 resolved duplex
// - Status bit 7 pause enabled
// - Status bit 6 negotiation done event
// - Status bit 5 remote fault event
// - Status bit 4 link fail event
// - Status bit 3 code word ack event
// - Status bit 2 parallel fault event
// - Status bit 1 page received event
// - Status bit 0 at 64 receive errors
`timescale 1ns/1ps
`include "pas_defines.svh"

module pas_regs
  import pas_pkg::*;
(
  input  wire logic                   sys_clk,           // 40 MHz clock
  input  wire logic                   rst_n,             // Sync reset
  input  wire logic [`PAS_ADDR_W-1:0] reg_addr,          // Byte address
  input  wire logic [`PAS_DATA_W-1:0] reg_wdata,         // Write data
  input  wire logic                   reg_wr,            // Write strobe
  input  wire logic                   reg_rd,            // Read strobe
  output logic      [`PAS_DATA_W-1:0] reg_rdata,         // Read data
  input  wire pas_partner_t           partner,           // Partner word
  input  wire pas_resolved_t          resolved,          // Resolution
  input  wire pas_event_t             events,            // Event pulses
  output logic                        long_cable_squelch // Squelch sel
);

  logic                   mode_ld_reg;
  logic                   pdf_reg;
  logic                   new_page_flag_reg;
  logic [6:0]             ev_reg;
  logic [6:0]             ev_next;
  logic [6:0]             ev_in;
  logic [6:0]             rxerr_cnt_reg;
  logic                   rxerr_full;
  logic                   rd_exp;
  logic                   rd_stat;
  logic [`PAS_DATA_W-1:0] rdata_next;

  assign rd_exp  = reg_rd && (reg_addr == `PAS_OFF_EXPANSION);
  assign rd_stat = reg_rd && (reg_addr == `PAS_OFF_STATUS);

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      mode_ld_reg <= `PAS_RST_LD;
    else if (reg_wr && reg_addr == `PAS_OFF_MODE_CTRL)
      mode_ld_reg <= reg_wdata[`PAS_BIT_LD];
  end
  assign long_cable_squelch = mode_ld_reg;

  // Receive error counting, saturates at limit
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      rxerr_cnt_reg <= 7'h00;
    else if (events.rx_err_pkt && rxerr_cnt_reg != `PAS_RXERR_LIMIT)
      rxerr_cnt_reg <= rxerr_cnt_reg + 7'h01;
  end
  assign rxerr_full = events.rx_err_pkt &&
                      (rxerr_cnt_reg == `PAS_RXERR_LIMIT - 7'h01);

  // Expansion latched flags, set wins over read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pdf_reg           <= 1'b0;
      new_page_flag_reg <= 1'b0;
    end else begin
      pdf_reg           <= events.par_fault | (pdf_reg & ~rd_exp);
      new_page_flag_reg <= events.page_rx |
                           (new_page_flag_reg & ~rd_exp);
    end
  end

  assign ev_in = {events.neg_done, events.remote_fault, events.link_fail,
                  events.code_word_ack, events.par_fault, events.page_rx,
                  rxerr_full};

  // Set beats clear in same cycle
  always_comb begin
    ev_next = ev_in | (ev_reg & {7{~rd_stat}});
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      ev_reg <= 7'h00;
    else
      ev_reg <= ev_next;
  end

  always_comb begin
    rdata_next = 16'h0000;
    unique case (reg_addr)
      `PAS_OFF_ABILITY: begin
        rdata_next[`PAS_BIT_T4]  = partner.t4;
        rdata_next[`PAS_BIT_TXF] = partner.fast_full;
        rdata_next[`PAS_BIT_TXH] = partner.fast_half;
        rdata_next[`PAS_BIT_10F] = partner.ten_full;
        rdata_next[`PAS_BIT_10H] = partner.ten_half;
        rdata_next[4:0]          = partner.selector;
      end
      `PAS_OFF_EXPANSION: begin
        rdata_next[`PAS_BIT_PDF]  = pdf_reg;
        rdata_next[`PAS_BIT_PARTNER_NEXT_PAGE_CAPABLE] = partner.next_page;
        rdata_next[`PAS_BIT_NP]   = 1'b0;
        rdata_next[`PAS_BIT_PR]   = new_page_flag_reg;
        rdata_next[`PAS_BIT_PARTNER_NEGOTIATION_CAPABLE] = partner.negotiation;
      end
      `PAS_OFF_MODE_CTRL: begin
        rdata_next[`PAS_BIT_LD] = mode_ld_reg;
      end
      `PAS_OFF_STATUS: begin
        rdata_next[`PAS_BIT_SPEED]  = resolved.speed_100;
        rdata_next[`PAS_BIT_DUPLEX] = resolved.full_duplex;
        rdata_next[`PAS_BIT_PAUSE]  = resolved.pause_on;
        rdata_next[6:0]             = ev_reg;
      end
      default: rdata_next = 16'h0000;
    endcase
  end

  // Data held only for the cycle after the read
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 16'h0000;
  end

  property p_ev_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (ev_reg[5] && !rd_stat) |=> ev_reg[5];
  endproperty
  a_ev_hold: assert property (p_ev_hold)
    else $error("Latched event lost without read");

  property p_set_wins;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_stat && events.neg_done) |=> ev_reg[6];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Event lost during status read");

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      (rd_stat && ev_in == 7'h00) |=> ev_reg == 7'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("Status not cleared by read");

  property p_link;
    @(posedge sys_clk) disable iff (!rst_n)
      events.link_fail |=> ev_reg[4];
  endproperty
  a_link: assert property (p_link)
    else $error("Link fail not latched");

  property p_pdf;
    @(posedge sys_clk) disable iff (!rst_n)
      events.par_fault |=> (pdf_reg && ev_reg[2]);
  endproperty
  a_pdf: assert property (p_pdf)
    else $error("Parallel fault not latched");

  property p_page;
    @(posedge sys_clk) disable iff (!rst_n)
      events.page_rx |=> (new_page_flag_reg && ev_reg[1]);
  endproperty
  a_page: assert property (p_page)
    else $error("Page flag not set");

  property p_np;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `PAS_OFF_EXPANSION) |=> !reg_rdata[2];
  endproperty
  a_np: assert property (p_np)
    else $error("Local next page read nonzero");

  property p_ld;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == `PAS_OFF_MODE_CTRL)
        |=> long_cable_squelch == $past(reg_wdata[11]);
  endproperty
  a_ld: assert property (p_ld)
    else $error("Squelch bit not written");

  property p_rxerr;
    @(posedge sys_clk) disable iff (!rst_n)
      (rxerr_cnt_reg < 7'h3f) |=> !($rose(ev_reg[0]));
  endproperty
  a_rxerr: assert property (p_rxerr)
    else $error("Error flag set below limit");

  property p_speed;
    @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr == `PAS_OFF_STATUS)
        |=> reg_rdata[9] == $past(resolved.speed_100);
  endproperty
  a_speed: assert property (p_speed)
    else $error("Speed bit mismatch");

endmodule : pas_regs

// File: verif/pas_partner_model.sv
`timescale 1ns/1ps
module pas_partner_model
  import pas_pkg::*;
(
  input  wire logic        sys_clk,  // Local clock
  input  wire logic [11:0] adv_word, // Advertised abilities
  input  wire logic        link_up,  // Code word arriving
  output pas_partner_t     partner   // Decoded word to device
);
  // Dead link carries no code word, so nothing is advertised
  always_ff @(posedge sys_clk) begin
    partner <= link_up ? pas_partner_t'(adv_word) : '0;
  end
endmodule : pas_partner_model

// File: verif/tb_phy_autoneg_status_regs.sv
`timescale 1ns/1ps
`include "pas_defines.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_phy_autoneg_status_regs
  import pas_pkg::*;
();
  logic          sys_clk, rst_n, reg_wr, reg_rd, squelch, link_up;
  logic [7:0]    reg_addr;
  logic [15:0]   reg_wdata, reg_rdata;
  logic [11:0]   adv, w;
  pas_partner_t  partner;
  pas_resolved_t resolved;
  pas_event_t    events;
  int            n_errors, n_compared;

  pas_partner_model i_partner (.sys_clk(sys_clk), .adv_word(adv),
    .link_up(link_up), .partner(partner));
  pas_regs i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .partner(partner), .resolved(resolved),
    .events(events), .long_cable_squelch(squelch));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK($sformatf("rdata_%h", a), e, reg_rdata)
  endtask : rd

  // A level held n cycles counts as n events
  task automatic pulse(input logic [6:0] e, input int n);
    @(posedge sys_clk);
    events <= pas_event_t'(e);
    repeat (n) @(posedge sys_clk);
    events <= '0;
  endtask : pulse

  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 16'h0000; adv = 12'h000; link_up = 1'b0;
    resolved = '0; events = '0; n_errors = 0; n_compared = 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`PAS_OFF_ABILITY, 16'h0000);
    rd(`PAS_OFF_EXPANSION, 16'h0000);
    rd(`PAS_OFF_MODE_CTRL, 16'h0000);
    rd(`PAS_OFF_STATUS, 16'h0000);
    rd(8'hd8, 16'h0000);
    link_up <= 1'b1;
    // One advertised ability at a time; i == 2 is selector 00001
    for (int i = 0; i < 12; i++) begin
      w = 12'h001 << i;
      adv <= w;
      repeat (2) @(posedge sys_clk);
      rd(`PAS_OFF_ABILITY, {6'h00, w[11:2]});
      rd(`PAS_OFF_EXPANSION, {12'h000, w[1], 2'b00, w[0]});
    end
    link_up <= 1'b0;
    wr(`PAS_OFF_MODE_CTRL, 16'hffff);
    rd(`PAS_OFF_MODE_CTRL, 16'h0800);
    `CHK("squelch", 1'b1, squelch)
    wr(`PAS_OFF_ABILITY, 16'hffff);
    wr(8'hd8, 16'hffff);
    rd(`PAS_OFF_ABILITY, 16'h0000);
    wr(`PAS_OFF_MODE_CTRL, 16'h0000);
    rd(`PAS_OFF_MODE_CTRL, 16'h0000);
    `CHK("squelch", 1'b0, squelch)
    resolved <= 3'b101;
    for (int k = 1; k < 7; k++) begin
      pulse(7'h01 << k, 1);
      repeat (3) @(posedge sys_clk);
      rd(`PAS_OFF_EXPANSION, {11'h000, k == 2, 2'b00, k == 1, 1'b0});
      rd(`PAS_OFF_EXPANSION, 16'h0000);
      rd(`PAS_OFF_STATUS, {6'h00, 3'b101, 7'h01 << k});
      rd(`PAS_OFF_STATUS, {6'h00, 3'b101, 7'h00});
    end
    resolved <= 3'b010;
    rd(`PAS_OFF_STATUS, {6'h00, 3'b010, 7'h00});
    pulse(7'h01, 63);
    rd(`PAS_OFF_STATUS, {6'h00, 3'b010, 7'h00});
    pulse(7'h01, 1);
    rd(`PAS_OFF_STATUS, {6'h00, 3'b010, 7'h01});
    rd(`PAS_OFF_STATUS, {6'h00, 3'b010, 7'h00});
    // Event landing in the very cycle of a clearing read
    @(posedge sys_clk);
    reg_addr <= `PAS_OFF_STATUS;
    reg_rd   <= 1'b1;
    events   <= pas_event_t'(7'h40);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    events <= '0;
    rd(`PAS_OFF_STATUS, {6'h00, 3'b010, 7'h40});
    end_sim();
  end
endmodule : tb_phy_autoneg_status_regs
